// ---- logic/lane_map_pkg.sv ----
/*
 * Shared constants and types of the transmit lane mapper: register
 * offsets, control field positions, reset values and frame geometry.
 * Assumes a 40 MHz single-clock system with a synchronous reset.
 */
package lane_map_pkg;

    typedef enum logic [1:0] {
        LM12 = 2'b00,
        LM13 = 2'b01,
        LM14 = 2'b10,
        LM15 = 2'b11
    } link_mode_t;

    typedef enum logic {
        ST_COLLECT = 1'b0,
        ST_SEND = 1'b1
    } frame_state_t;

    localparam int LANES = 8;
    localparam int SAMP_W = 9;
    localparam int CHANS = 4;
    localparam int BUF_W = 40;
    localparam int FIFO_DEPTH = 16;

    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_FEC_BIT = 8;
    localparam int CTRL_ALT_BIT = 9;
    localparam int CTRL_GPD_BIT = 10;
    localparam int CTRL_PAIR_LSB = 11;
    localparam int CTRL_SINGLE_BIT = 13;

    localparam logic [4:0] MODE_NUM_12 = 5'h0c;
    localparam logic [4:0] MODE_NUM_13 = 5'h0d;
    localparam logic [4:0] MODE_NUM_14 = 5'h0e;
    localparam logic [4:0] MODE_NUM_15 = 5'h0f;
    localparam logic [4:0] MODE_RESET = 5'h0e;
    localparam logic [1:0] PAIR_RESET = 2'h3;

    localparam logic [3:0] INST_12 = 4'h3;
    localparam logic [3:0] INST_13 = 4'hf;
    localparam logic [3:0] INST_14 = 4'h3;
    localparam logic [3:0] INST_15 = 4'h7;
    localparam logic [2:0] OCT_12 = 3'h0;
    localparam logic [2:0] OCT_13 = 3'h4;
    localparam logic [2:0] OCT_14 = 3'h2;
    localparam logic [2:0] OCT_15 = 3'h2;

endpackage : lane_map_pkg

// ---- logic/sample_stream_if.sv ----
/*
 * Valid/ready stream carrying one conversion instant of all channels.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface sample_stream_if #(parameter int WIDTH = 36);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sample_stream_if

// ---- logic/sample_fifo.sv ----
/*
 * Sample FIFO with registered read data and a registered ready.
 * Assumes the sink may stall; flush empties it at once.
 */
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic flush,
    sample_stream_if.snk wr,
    sample_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] cnt_q;
    logic [AW:0] cnt_d;
    logic room_q;
    logic rval_q;
    logic [WIDTH-1:0] rdat_q;

    wire push = wr.valid && room_q;
    wire pop = (cnt_q != '0) && (!rval_q || rd.ready);

    assign cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign wr.ready = room_q;
    assign rd.valid = rval_q;
    assign rd.data = rdat_q;

    // Storage is left out of reset so it maps onto plain RAM
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wptr_q] <= wr.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || flush) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
            room_q <= 1'b0;
            rval_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            if (push) wptr_q <= wptr_q + 1'b1;
            if (pop) rptr_q <= rptr_q + 1'b1;
            cnt_q <= cnt_d;
            room_q <= (cnt_d != FULL_CNT);
            if (pop) begin
                rval_q <= 1'b1;
                rdat_q <= mem_q[rptr_q];
            end else if (rd.ready) begin
                rval_q <= 1'b0;
            end
        end
    end

endmodule : sample_fifo

// ---- logic/lane_mapper.sv ----
/*
 * Transmit transport mapper: packs per-instant channel samples into
 * lane octets for link modes 12 to 15, with lane redundancy and
 * power-down gating. Registers are reached over Avalon-MM.
 * Assumes one 40 MHz clock, synchronous inputs and a link layer
 * downstream that takes one octet per lane per valid cycle.
 */
// What this block does
// - Mode 12 sends one 8-bit sample per lane; A on 0-3, B on 4-7.
// - Mode 13 pads 9-bit samples to 10; lane k holds k,k+4,k+8,k+12.
// - Mode 14 pads to 12; lane pairs per channel, even samples even lane.
// - Mode 15 pads to 12; lane k carries samples k and k+4.
// - Sync header offers only the 12-bit CRC, never the 3-bit one.
// - Sync header may instead be set to forward error correction.
// - Lane redundancy is allowed only when four lanes or fewer are used.
// - Alternate select 0 picks the lower group, 1 the upper group.
// - Only one lane group is driven at a time while redundancy applies; eight-lane use drives both.
// - Power-down pin high powers down and disables the lane drivers.
// - Global mode setting also forces full power-down, pin regardless.
// - Settings survive power-down and the return to operation.
// - Channels power down in pairs; never disable all four that way.
`timescale 1ns/100ps
module lane_mapper (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic power_down_pin,
    input wire logic samp_valid,
    output logic samp_ready,
    input wire logic [35:0] samp_data,
    output logic [63:0] lane_data,
    output logic lane_valid,
    output logic lane_frame_start,
    output logic lane_frame_end,
    output logic [7:0] lane_drv_en,
    output logic sync_hdr_fec,
    output logic enc_8b10b
);
    localparam int WORD_W = lane_map_pkg::CHANS * lane_map_pkg::SAMP_W;

    function automatic logic [3:0] last_inst(
        input lane_map_pkg::link_mode_t m);
        case (m)
            lane_map_pkg::LM12: last_inst = lane_map_pkg::INST_12;
            lane_map_pkg::LM13: last_inst = lane_map_pkg::INST_13;
            lane_map_pkg::LM14: last_inst = lane_map_pkg::INST_14;
            default: last_inst = lane_map_pkg::INST_15;
        endcase
    endfunction : last_inst

    function automatic logic [2:0] last_oct(input lane_map_pkg::link_mode_t m);
        case (m)
            lane_map_pkg::LM12: last_oct = lane_map_pkg::OCT_12;
            lane_map_pkg::LM13: last_oct = lane_map_pkg::OCT_13;
            lane_map_pkg::LM14: last_oct = lane_map_pkg::OCT_14;
            default: last_oct = lane_map_pkg::OCT_15;
        endcase
    endfunction : last_oct

    // Sample left-aligned in a lane buffer with its zero padding below
    function automatic logic [39:0] field_of(
        input lane_map_pkg::link_mode_t m,
        input logic [8:0] s
    );
        case (m)
            lane_map_pkg::LM12: field_of = {s[8:1], 32'h0};
            lane_map_pkg::LM13: field_of = {s, 1'b0, 30'h0};
            default: field_of = {s, 3'h0, 28'h0};
        endcase
    endfunction : field_of

    // Control register fields, bus handshake state and frame count
    logic [4:0] mode_num_q;
    logic fec_q;
    logic alt_q;
    logic gpd_q;
    logic [1:0] pair_q;
    logic single_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [15:0] frames_q;

    lane_map_pkg::frame_state_t st_q;
    logic [3:0] inst_q;
    logic [2:0] oct_q;
    logic [7:0][39:0] buf_q;
    logic [7:0][39:0] buf_d;

    sample_stream_if #(.WIDTH(WORD_W)) in_s ();
    sample_stream_if #(.WIDTH(WORD_W)) out_s ();

    assign in_s.valid = samp_valid;
    assign in_s.data = samp_data;
    assign samp_ready = in_s.ready;

    // Power-down on the pin or the global setting
    wire pd = power_down_pin || gpd_q;

    sample_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(lane_map_pkg::FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .flush(pd),
        .wr(in_s),
        .rd(out_s)
    );

    // Mode decode
    wire lane_map_pkg::link_mode_t mode = lane_map_pkg::link_mode_t'(
        mode_num_q[1:0]);
    wire is_m14 = (mode == lane_map_pkg::LM14);
    wire fits4 = is_m14 ? (pair_q != 2'b11) : single_q;
    wire upper_only = is_m14 && (pair_q == 2'b10);
    wire [7:0] drv_mask = !fits4 ? 8'hff : (alt_q ? 8'hf0 : 8'h0f);

    // Register bus decode
    wire bus_req = avs_read || avs_write;
    wire wr_take = avs_write && !wait_q;
    wire ctrl_hit = (avs_address == lane_map_pkg::CTRL_OFS);
    wire stat_hit = (avs_address == lane_map_pkg::STAT_OFS);
    wire [4:0] wr_mode = avs_writedata[lane_map_pkg::CTRL_MODE_LSB +: 5];
    wire mode_ok = (wr_mode >= lane_map_pkg::MODE_NUM_12) &&
        (wr_mode <= lane_map_pkg::MODE_NUM_15);
    wire [1:0] wr_pair = avs_writedata[lane_map_pkg::CTRL_PAIR_LSB +: 2];
    wire wr_b0 = wr_take && ctrl_hit && avs_byteenable[0];
    wire wr_b1 = wr_take && ctrl_hit && avs_byteenable[1];
    wire [31:0] ctrl_word = {18'h0, single_q, pair_q, gpd_q, alt_q, fec_q,
        3'h0, mode_num_q};
    wire [31:0] stat_word = {frames_q, lane_drv_en, 5'h0, fits4, pd,
        (st_q == lane_map_pkg::ST_SEND)};
    wire [31:0] rd_word = ctrl_hit ? ctrl_word :
        (stat_hit ? stat_word : 32'h0);

    // Framer handshake
    wire take = out_s.valid && out_s.ready;
    wire inst_last = (inst_q == last_inst(mode));
    wire oct_last = (oct_q == last_oct(mode));
    assign out_s.ready = (st_q == lane_map_pkg::ST_COLLECT) && !pd;

    // Place the incoming instant into each lane buffer it belongs to
    always_comb begin
        logic [1:0] ch;
        logic hit;
        logic [1:0] slot;
        logic [5:0] shamt;
        logic [8:0] s;
        buf_d = buf_q;
        ch = 2'h0;
        hit = 1'b0;
        slot = 2'h0;
        shamt = 6'h0;
        s = 9'h0;
        for (int l = 0; l < lane_map_pkg::LANES; l++) begin
            case (mode)
                lane_map_pkg::LM12: begin
                    ch = 2'(l / 4);
                    hit = (inst_q[1:0] == 2'(l % 4)) && !inst_q[3] &&
                        !inst_q[2];
                    slot = 2'h0;
                    shamt = 6'h0;
                end
                lane_map_pkg::LM14: begin
                    ch = 2'(l / 2);
                    hit = (inst_q[0] == 1'(l % 2)) &&
                        pair_q[l / 4];
                    slot = {1'b0, inst_q[1]};
                    shamt = 6'(slot * 12);
                end
                default: begin
                    ch = 2'(l / 4);
                    hit = (inst_q[1:0] == 2'(l % 4));
                    slot = inst_q[3:2];
                    shamt = (mode == lane_map_pkg::LM13) ?
                        6'(slot * 10) : 6'(slot * 12);
                end
            endcase
            if (!is_m14 && single_q && ch != 2'h0) begin
                hit = 1'b0;
            end
            s = samp_data_of(out_s.data, ch);
            if (take && hit) begin
                buf_d[l] = buf_q[l] | (field_of(mode, s) >> shamt);
            end
        end
    end

    function automatic logic [8:0] samp_data_of(
        input logic [35:0] w,
        input logic [1:0] ch
    );
        samp_data_of = w[ch * 9 +: 9];
    endfunction : samp_data_of

    // Octet extraction and redundant-group routing
    logic [7:0][7:0] lg;
    logic [63:0] routed;
    always_comb begin
        logic [39:0] t;
        t = 40'h0;
        for (int l = 0; l < lane_map_pkg::LANES; l++) begin
            t = buf_q[l] << {oct_q, 3'b000};
            lg[l] = t[39:32];
        end
        for (int j = 0; j < 4; j++) begin
            if (!fits4) begin
                routed[j*8 +: 8] = lg[j];
                routed[(j+4)*8 +: 8] = lg[j+4];
            end else begin
                routed[j*8 +: 8] = alt_q ? 8'h0 :
                    (upper_only ? lg[j+4] : lg[j]);
                routed[(j+4)*8 +: 8] = !alt_q ? 8'h0 :
                    (upper_only ? lg[j+4] : lg[j]);
            end
        end
    end

    // Register bus: one wait cycle, answer on the second edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= !(bus_req && wait_q);
            if (avs_read && wait_q) begin
                rdata_q <= rd_word;
            end
        end
    end

    // Only srst clears the settings, so they outlive any power-down
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_num_q <= lane_map_pkg::MODE_RESET;
            fec_q <= 1'b0;
            alt_q <= 1'b0;
            gpd_q <= 1'b0;
            pair_q <= lane_map_pkg::PAIR_RESET;
            single_q <= 1'b0;
        end else begin
            if (wr_b0 && mode_ok) begin
                mode_num_q <= wr_mode;
            end
            if (wr_b1) begin
                fec_q <= avs_writedata[lane_map_pkg::CTRL_FEC_BIT];
                alt_q <= avs_writedata[lane_map_pkg::CTRL_ALT_BIT];
                gpd_q <= avs_writedata[lane_map_pkg::CTRL_GPD_BIT];
                single_q <= avs_writedata[lane_map_pkg::CTRL_SINGLE_BIT];
                if (wr_pair != 2'b00) begin
                    pair_q <= wr_pair;
                end
            end
        end
    end

    // Frame state machine
    always_ff @(posedge sys_clk) begin
        if (srst || pd) begin
            st_q <= lane_map_pkg::ST_COLLECT;
            inst_q <= 4'h0;
            oct_q <= 3'h0;
            buf_q <= '0;
        end else begin
            case (st_q)
                lane_map_pkg::ST_COLLECT: begin
                    buf_q <= buf_d;
                    if (take) begin
                        inst_q <= inst_last ? 4'h0 : inst_q + 4'h1;
                        if (inst_last) st_q <= lane_map_pkg::ST_SEND;
                    end
                end
                lane_map_pkg::ST_SEND: begin
                    oct_q <= oct_last ? 3'h0 : oct_q + 3'h1;
                    if (oct_last) begin
                        st_q <= lane_map_pkg::ST_COLLECT;
                        buf_q <= '0;
                    end
                end
                default: st_q <= lane_map_pkg::ST_COLLECT;
            endcase
        end
    end

    // Registered lane outputs
    wire sending = (st_q == lane_map_pkg::ST_SEND) && !pd;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lane_data <= 64'h0;
            lane_valid <= 1'b0;
            lane_frame_start <= 1'b0;
            lane_frame_end <= 1'b0;
            lane_drv_en <= 8'h0;
            sync_hdr_fec <= 1'b0;
            enc_8b10b <= 1'b0;
            frames_q <= 16'h0;
        end else begin
            lane_data <= sending ? routed : 64'h0;
            lane_valid <= sending;
            lane_frame_start <= sending && (oct_q == 3'h0);
            lane_frame_end <= sending && oct_last;
            lane_drv_en <= pd ? 8'h0 : drv_mask;
            sync_hdr_fec <= fec_q && !enc_8b10b;
            enc_8b10b <= (mode == lane_map_pkg::LM13);
            if (sending && oct_last) frames_q <= frames_q + 16'h1;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;

    a_groups_exclusive: assert property (
        @(posedge sys_clk) disable iff (srst)
        fits4 |=> !((|lane_drv_en[3:0]) && (|lane_drv_en[7:4])))
        else $error("both lane groups driven while redundancy applies");
    a_pin_drivers_off: assert property (
        @(posedge sys_clk) disable iff (srst)
        power_down_pin |=> (lane_drv_en == 8'h0) && !lane_valid)
        else $error("lane drivers active while power-down pin high");
    a_global_pd_off: assert property (
        @(posedge sys_clk) disable iff (srst)
        gpd_q && !power_down_pin |=> lane_drv_en == 8'h0)
        else $error("lane drivers active under global power-down");
    a_alt_upper_group: assert property (
        @(posedge sys_clk) disable iff (srst)
        fits4 && !pd && alt_q |=> lane_drv_en == 8'hf0)
        else $error("alternate select did not pick upper lane group");
    a_no_redund_wide: assert property (
        @(posedge sys_clk) disable iff (srst)
        !fits4 && !pd |=> lane_drv_en == 8'hff)
        else $error("lane group switched in an eight-lane mode");
    a_mode13_frame_len: assert property (
        @(posedge sys_clk) disable iff (srst || pd)
        lane_frame_start && enc_8b10b && !$past(pd) |->
            lane_valid [*5] ##0 lane_frame_end ##1 !lane_valid)
        else $error("mode 13 frame is not five octets long");
    a_mode12_one_oct: assert property (
        @(posedge sys_clk) disable iff (srst)
        lane_frame_start && $past(mode) == lane_map_pkg::LM12 &&
            $past(mode) == mode |-> lane_frame_end)
        else $error("mode 12 frame is not a single octet");
    a_pad_bits_zero: assert property (
        @(posedge sys_clk) disable iff (srst)
        lane_valid && !lane_frame_start && !lane_frame_end &&
            !enc_8b10b && $past(mode) != lane_map_pkg::LM12 |->
            lane_data[6:4] == 3'h0)
        else $error("padding bits of a 12-bit field are not zero");
    a_cfg_kept_pd: assert property (
        @(posedge sys_clk) disable iff (srst)
        pd && !wr_take |=> $stable(mode_num_q) && $stable(pair_q) &&
            $stable(fec_q))
        else $error("settings changed during power-down");
    a_pairs_never_off: assert property (
        @(posedge sys_clk) disable iff (srst)
        wr_b1 && wr_pair == 2'b00 |=> pair_q != 2'b00)
        else $error("channel pair enable reached all-off");

endmodule : lane_mapper

// ---- bench/lane_receiver.sv ----
/*
 * Behavioural model of the serial link receiver beside the lane mapper.
 * Assumes one octet per lane per valid cycle, MSB first on each lane.
 * Holds the octets of the last whole frame, right aligned per lane.
 */
`timescale 1ns/100ps
module lane_receiver (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [63:0] lane_data,
    input wire logic lane_valid,
    input wire logic lane_frame_start,
    input wire logic lane_frame_end,
    input wire logic [7:0] lane_drv_en,
    output logic [319:0] cap_q,
    output logic [3:0] octets_q,
    output logic [15:0] frames_q
);
    logic busy_q;

    always @(posedge sys_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            cap_q <= '0;
            octets_q <= '0;
            frames_q <= '0;
        end else if (lane_drv_en == 8'h00) begin
            // Lost link: a half-received frame is stale, so drop it
            busy_q <= 1'b0;
        end else if (lane_valid && (lane_frame_start || busy_q)) begin
            busy_q <= !lane_frame_end;
            octets_q <= lane_frame_start ? 4'h1 : octets_q + 4'h1;
            if (lane_frame_end) begin
                frames_q <= frames_q + 16'h1;
            end
            // A lane whose driver is off reads as silence, not as data
            for (int k = 0; k < 8; k++) begin
                cap_q[40*k +: 40] <= {lane_frame_start ? 32'h0 :
                    cap_q[40*k +: 32],
                    lane_drv_en[k] ? lane_data[8*k +: 8] : 8'h00};
            end
        end
    end
endmodule : lane_receiver

// ---- bench/lane_mapper_test.sv ----
/*
 * Self-checking bench of the lane mapper: register tests over Avalon-MM,
 * one frame per link mode, lane redundancy and power-down.
 * Assumes the receiver model sits on the lane outputs.
 */
`timescale 1ns/100ps
module lane_mapper_test;
    logic sys_clk, srst, avs_read, avs_write, power_down_pin;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic avs_waitrequest, samp_valid, samp_ready, lane_valid;
    logic [35:0] samp_data;
    logic [63:0] lane_data;
    logic lane_frame_start, lane_frame_end, sync_hdr_fec, enc_8b10b;
    logic [7:0] lane_drv_en;
    logic [319:0] cap;
    logic [3:0] octets;
    logic [15:0] frames;
    logic [8:0] smp [16][4];
    int miscompares = 0;
    int cmp_count = 0;

    lane_mapper uut (.sys_clk(sys_clk), .srst(srst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .power_down_pin(power_down_pin), .samp_valid(samp_valid),
        .samp_ready(samp_ready), .samp_data(samp_data),
        .lane_data(lane_data), .lane_valid(lane_valid),
        .lane_frame_start(lane_frame_start),
        .lane_frame_end(lane_frame_end), .lane_drv_en(lane_drv_en),
        .sync_hdr_fec(sync_hdr_fec), .enc_8b10b(enc_8b10b));

    lane_receiver rx (.sys_clk(sys_clk), .srst(srst),
        .lane_data(lane_data), .lane_valid(lane_valid),
        .lane_frame_start(lane_frame_start),
        .lane_frame_end(lane_frame_end), .lane_drv_en(lane_drv_en),
        .cap_q(cap), .octets_q(octets), .frames_q(frames));

    always #12.5 sys_clk = ~sys_clk;

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_rd

    function automatic logic [31:0] ctrl(input logic [4:0] mn,
        input logic fec, input logic alt, input logic gpd,
        input logic [1:0] pr, input logic sgl);
        logic [31:0] v;
        v = 32'h0;
        v[4:0] = mn;
        v[lane_map_pkg::CTRL_FEC_BIT] = fec;
        v[lane_map_pkg::CTRL_ALT_BIT] = alt;
        v[lane_map_pkg::CTRL_GPD_BIT] = gpd;
        v[lane_map_pkg::CTRL_PAIR_LSB +: 2] = pr;
        v[lane_map_pkg::CTRL_SINGLE_BIT] = sgl;
        return v;
    endfunction : ctrl

    // Octets of one lane, oldest first, right aligned
    function automatic logic [39:0] exp_lane(input int m, input int k);
        int j;
        int c;
        j = k % 4;
        c = k / 4;
        case (m)
            12: return {32'h0, smp[j][c][8:1]};
            13: return {smp[j][c], 1'b0, smp[j+4][c], 1'b0,
                        smp[j+8][c], 1'b0, smp[j+12][c], 1'b0};
            14: return {16'h0, smp[k%2][k/2], 3'h0,
                        smp[k%2+2][k/2], 3'h0};
            default: return {16'h0, smp[j][c], 3'h0, smp[j+4][c], 3'h0};
        endcase
    endfunction : exp_lane

    task automatic wait_en(input logic [7:0] e);
        for (int n = 0; n < 20 && lane_drv_en !== e; n++) begin
            @(posedge sys_clk);
        end
        check("lane_drv_en", lane_drv_en, e);
    endtask : wait_en

    task automatic run_frame(input logic [4:0] mn, input int m,
        input logic sgl, input logic alt, input int words, input int f);
        logic fit;
        logic [7:0] en;
        logic [15:0] fr;
        logic [39:0] e;
        fit = (m != 14) && sgl;
        en = fit ? (alt ? 8'hf0 : 8'h0f) : 8'hff;
        bus_wr(lane_map_pkg::CTRL_OFS, ctrl(mn, 1'b0, alt, 1'b0, 2'h3, sgl));
        wait_en(en);
        for (int i = 0; i < 16; i++) begin
            for (int c = 0; c < 4; c++) begin
                smp[i][c] = 9'(i * 29 + c * 77 + m * 13 + 256 * (i % 2));
            end
        end
        fr = frames;
        for (int i = 0; i < words; i++) begin
            samp_valid <= 1'b1;
            samp_data <= {smp[i][3], smp[i][2], smp[i][1], smp[i][0]};
            do @(posedge sys_clk); while (samp_ready !== 1'b1);
        end
        samp_valid <= 1'b0;
        for (int n = 0; n < 300 && frames === fr; n++) begin
            @(posedge sys_clk);
        end
        check("octets", octets, 64'(f));
        for (int k = 0; k < 8; k++) begin
            e = fit ? ((en[k]) ? exp_lane(m, k % 4) : 40'h0) : exp_lane(m, k);
            check("lane", cap[40*k +: 40], e);
        end
        $display("test mode %0d single %0d alt %0d done", m, sgl, alt);
    endtask : run_frame

    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        wrap_up();
    end

    initial begin
        sys_clk = 1'b0;
        srst = 1'b1;
        {avs_read, avs_write, power_down_pin, samp_valid} = 4'h0;
        avs_address = 4'h0;
        avs_byteenable = 4'h3;
        avs_writedata = 32'h0;
        samp_data = 36'h0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        bus_rd(lane_map_pkg::CTRL_OFS, q);
        check("ctrl_reset", q, ctrl(lane_map_pkg::MODE_RESET, 1'b0, 1'b0,
            1'b0, lane_map_pkg::PAIR_RESET, 1'b0));
        bus_wr(4'h8, 32'hffff_ffff);
        bus_rd(4'h8, q);
        check("unmapped", q, 64'h0);
        check("sync_hdr_fec", sync_hdr_fec, 64'h0);
        $display("test registers done");
        run_frame(lane_map_pkg::MODE_NUM_14, 14, 1'b0, 1'b1, 4, 3);
        run_frame(lane_map_pkg::MODE_NUM_12, 12, 1'b0, 1'b0, 4, 1);
        run_frame(lane_map_pkg::MODE_NUM_13, 13, 1'b0, 1'b0, 16, 5);
        check("enc_8b10b", enc_8b10b, 64'h1);
        run_frame(lane_map_pkg::MODE_NUM_15, 15, 1'b0, 1'b0, 8, 3);
        run_frame(lane_map_pkg::MODE_NUM_15, 15, 1'b1, 1'b0, 8, 3);
        run_frame(lane_map_pkg::MODE_NUM_15, 15, 1'b1, 1'b1, 8, 3);
        run_frame(lane_map_pkg::MODE_NUM_12, 12, 1'b1, 1'b1, 4, 1);
        // Bad mode and all-pairs-off are refused, the rest lands
        bus_wr(lane_map_pkg::CTRL_OFS, ctrl(5'h10, 1'b1, 1'b0, 1'b0,
            2'h0, 1'b0));
        bus_rd(lane_map_pkg::CTRL_OFS, q);
        check("ctrl_refuse", q, ctrl(lane_map_pkg::MODE_NUM_12, 1'b1, 1'b0,
            1'b0, 2'h3, 1'b0));
        check("sync_hdr_fec", sync_hdr_fec, 64'h1);
        bus_wr(lane_map_pkg::CTRL_OFS, ctrl(lane_map_pkg::MODE_NUM_14, 1'b0,
            1'b0, 1'b0, 2'h1, 1'b0));
        wait_en(8'h0f);
        $display("test refusals done");
        q = ctrl(lane_map_pkg::MODE_NUM_14, 1'b0, 1'b0, 1'b0, 2'h3, 1'b0);
        bus_wr(lane_map_pkg::CTRL_OFS, q);
        power_down_pin <= 1'b1;
        wait_en(8'h00);
        check("samp_ready", samp_ready, 64'h0);
        bus_rd(lane_map_pkg::STAT_OFS, q);
        check("stat_pd", q[1], 64'h1);
        // Settings are held, so no rewrite is due after waking
        power_down_pin <= 1'b0;
        bus_rd(lane_map_pkg::CTRL_OFS, q);
        check("ctrl_kept", q, ctrl(lane_map_pkg::MODE_NUM_14, 1'b0, 1'b0,
            1'b0, 2'h3, 1'b0));
        run_frame(lane_map_pkg::MODE_NUM_14, 14, 1'b0, 1'b0, 4, 3);
        bus_wr(lane_map_pkg::CTRL_OFS, ctrl(lane_map_pkg::MODE_NUM_14, 1'b0,
            1'b0, 1'b1, 2'h3, 1'b0));
        wait_en(8'h00);
        bus_rd(lane_map_pkg::STAT_OFS, q);
        check("stat_gpd", q[1], 64'h1);
        bus_wr(lane_map_pkg::CTRL_OFS, ctrl(lane_map_pkg::MODE_NUM_14, 1'b0,
            1'b0, 1'b0, 2'h3, 1'b0));
        wait_en(8'hff);
        $display("test power down done");
        wrap_up();
    end
endmodule : lane_mapper_test
